/* File: hw/pas_defs.svh */
/*
 Constants for the association sequencer: flag bits, timing, codes.
 Assumes a 50 MHz system clock.
*/
`ifndef PAS_DEFS_SVH
`define PAS_DEFS_SVH
`define PAS_FLAG_PAN_RESEL 0
`define PAS_FLAG_CH_RESEL 1
`define PAS_FLAG_AUTO_JOIN 2
`define PAS_FLAG_ALLOW_JOIN 2
`define PAS_BCAST_ADDR 16'hFFFF
`define PAS_BCAST_PAN 16'hFFFF
`define PAS_MAX_NETS 5
`define PAS_CLK_HZ 50000000
`define PAS_BLINK_COORD_HZ 1
`define PAS_BLINK_ASSOC_HZ 2
`define PAS_BLINK_NOJOIN_HZ 5
`define PAS_HALF_CYC(hz) ((`PAS_CLK_HZ) / ((hz) * 2))
`define PAS_AI_OK 8'h00
`define PAS_AI_SCANNING 8'h01
`define PAS_AI_NO_COORD 8'h02
`define PAS_AI_WAIT_CONF 8'h03
`define PAS_AI_NOT_STARTED 8'h04
`endif

/* File: hw/pas_pkg.sv */
/*
 Types for the association sequencer.
 Assumes pas_defs.svh is available.
*/
package pas_pkg;
	typedef enum logic [3:0] {
		PAS_IDLE = 4'h0,
		PAS_SCAN_TX = 4'h1,
		PAS_SCAN_LISTEN = 4'h3,
		PAS_ESCAN = 4'h2,
		PAS_PICK = 4'h6,
		PAS_RUN = 4'h7,
		PAS_ASSOC_TX = 4'h5,
		PAS_ASSOC_WAIT = 4'h4,
		PAS_FAIL = 4'hC
	} pas_state_type;
	typedef enum logic [1:0] {
		PAS_LED_ON = 2'h0,
		PAS_LED_1HZ = 2'h1,
		PAS_LED_2HZ = 2'h2,
		PAS_LED_5HZ = 2'h3
	} pas_led_type;
endpackage : pas_pkg

/* File: hw/pas_blinker.sv */
/*
 Association indicator driver: steady on or blink at 1, 2 or 5 Hz.
 Assumes a 50 MHz sys_clk.
*/
`timescale 1ns/1ps
`include "pas_defs.svh"
module pas_blinker #(
	parameter int CYC_1HZ = `PAS_HALF_CYC(`PAS_BLINK_COORD_HZ),
	parameter int CYC_2HZ = `PAS_HALF_CYC(`PAS_BLINK_ASSOC_HZ),
	parameter int CYC_5HZ = `PAS_HALF_CYC(`PAS_BLINK_NOJOIN_HZ)
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire pas_pkg::pas_led_type mode,
	output logic led
);
	logic [24:0] cnt_q;
	logic led_q;
	wire [24:0] half_w = (mode == pas_pkg::PAS_LED_1HZ) ? 25'(CYC_1HZ) :
		(mode == pas_pkg::PAS_LED_2HZ) ? 25'(CYC_2HZ) : 25'(CYC_5HZ);
	wire wrap_w = (cnt_q >= half_w - 25'h0000001);
	always_ff @(posedge sys_clk) begin
		if (!nrst || mode == pas_pkg::PAS_LED_ON) begin
			cnt_q <= 25'h0000000;
			led_q <= 1'b1;
		end else if (wrap_w) begin
			cnt_q <= 25'h0000000;
			led_q <= ~led_q;
		end else begin
			cnt_q <= cnt_q + 25'h0000001;
		end
	end
	assign led = led_q;
	a_steady_on: assert property (@(posedge sys_clk) // [R11]
		disable iff (!nrst) mode == pas_pkg::PAS_LED_ON |=> led)
		else $error("led not solid");
endmodule : pas_blinker

/* File: hw/pas_best_pick.sv */
/*
 Least-value selector over a vector of entries, with an exclusion mask.
 Used for energy minimum and, by inverting, link-quality maximum.
*/
`timescale 1ns/1ps
module pas_best_pick #(
	parameter int N = 16,
	parameter int W = 8
) (
	input wire logic [N*W-1:0] vals,
	input wire logic [N-1:0] excl,
	output logic found,
	output logic [$clog2(N)-1:0] idx
);
	logic [W-1:0] best [N+1];
	logic [$clog2(N)-1:0] bidx [N+1];
	logic bf [N+1];
	assign best[0] = {W{1'b1}};
	assign bidx[0] = '0;
	assign bf[0] = 1'b0;
	for (genvar i = 0; i < N; i++) begin : g_cmp
		wire [W-1:0] v = vals[i*W +: W];
		wire take = !excl[i] && (!bf[i] || v < best[i]);
		assign best[i+1] = take ? v : best[i];
		assign bidx[i+1] = take ? ($clog2(N))'(i) : bidx[i];
		assign bf[i+1] = bf[i] | !excl[i];
	end
	assign found = bf[N];
	assign idx = bidx[N];
endmodule : pas_best_pick

/* File: hw/pas_seq.sv */
/*
 Power-up and association sequencer for a PAN node, both roles.
 Assumes a MAC that sends beacon requests, reports beacons, measures
 energy and exchanges association messages over a strobe interface.
*/
// Operation
// [R1] Coordinator role when role enable is 1, end-device role when 0.
// [R2] Retention zero sends at once; else hold pending data, then discard.
// [R3] Coordinator pan_reselect set: active scan, beacon requests, listen.
// [R4] Scan stops after all channels or five networks; record pan, channel.
// [R5] Keep pan_identifier unless scanned; else use an undetected value.
// [R6] Coordinator pan_reselect clear: keep pan_identifier, no active scan.
// [R7] channel_reselect set: energy-scan each channel, keep maximum energy.
// [R8] Pick channel of least energy, excluding occupied channels.
// [R9] channel_reselect clear: keep channel_select, skip energy scan.
// [R10] Start on chosen channel and pan; accept joins only with allow_join.
// [R11] Coordinator indicator blinks 1 Hz once started, solid otherwise.
// [R12] Writes to reselect, pan, channel, address reset MAC only.
// [R13] Software should not change those settings after start.
// [R14] auto_join set: try to join; clear: associated, 5 Hz blink.
// [R15] End device active-scans channels, stops at all or five networks.
// [R16] pan_reselect set accepts any pan; clear needs matching pan.
// [R17] channel_reselect set accepts any channel; clear needs own channel.
// [R18] Reject coordinators not permitting joins or not non-beacon.
// [R19] Among candidates choose strongest link quality.
// [R20] No valid coordinator: sleep per sleep_select or retry.
// [R21] Send join request, wait confirm; 2 Hz blink after, solid before.
// [R22] Write to flags, pan or channel after joining restarts procedure.
// [R23] Join failure reported on assoc_indication.
// [R24] Scans visit channels in ascending order, one at a time.
`timescale 1ns/1ps
`include "pas_defs.svh"
module pas_seq #(
	parameter int NCH = 16,
	parameter int CHW = 4,
	parameter int LQW = 8
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic coord_enable,
	input wire logic [7:0] coord_assoc_flags,
	input wire logic [7:0] enddev_assoc_flags,
	input wire logic [15:0] pan_identifier,
	input wire logic [CHW-1:0] channel_select,
	input wire logic [15:0] short_source_addr,
	input wire logic [15:0] retention_period,
	input wire logic [15:0] scan_duration,
	input wire logic [2:0] sleep_select,
	input wire logic cfg_write,
	input wire logic pend_valid,
	input wire logic mac_scan_tick,
	input wire logic bcn_valid,
	input wire logic [15:0] bcn_pan,
	input wire logic [CHW-1:0] bcn_channel,
	input wire logic bcn_permit,
	input wire logic bcn_nonbeacon,
	input wire logic [LQW-1:0] bcn_lq,
	input wire logic ed_valid,
	input wire logic [7:0] ed_level,
	input wire logic assoc_confirm,
	output logic beacon_req,
	output logic [15:0] req_dst_addr,
	output logic [15:0] req_dst_pan,
	output logic energy_scan,
	output logic [CHW-1:0] scan_channel,
	output logic [15:0] scan_time,
	output logic assoc_req,
	output logic [15:0] assoc_pan,
	output logic mac_reset,
	output logic coord_started,
	output logic join_accept_en,
	output logic associated,
	output logic [15:0] active_pan,
	output logic [CHW-1:0] active_channel,
	output logic send_direct,
	output logic [15:0] pend_hold,
	output logic pend_discard,
	output logic sleep_req,
	output logic [2:0] sleep_mode,
	output logic [7:0] assoc_indication,
	output logic assoc_led
);
	pas_pkg::pas_state_type st_q, st_d;
	logic [CHW-1:0] ch_q;
	logic [2:0] nets_q;
	logic [15:0] npan_q [`PAS_MAX_NETS];
	logic [NCH-1:0] occ_q;
	logic [7:0] emax_q [NCH];
	logic [LQW-1:0] clq_q [NCH];
	logic [15:0] cpan_q [NCH];
	logic [NCH-1:0] cand_q;
	logic escan_q, did_active_q;
	logic [15:0] pan_q, hold_q;
	logic [CHW-1:0] chan_q;
	logic [7:0] ai_q;
	logic started_q, assoc_q, mac_rst_q;
	logic [7:0] flags_last_q, cflags_last_q;
	logic [15:0] pan_last_q, addr_last_q;
	logic [CHW-1:0] ch_last_q;
	////////////////////////////////////////////////////////////////
	// Configuration decode
	wire pan_rs_c = coord_assoc_flags[`PAS_FLAG_PAN_RESEL];
	wire ch_rs_c = coord_assoc_flags[`PAS_FLAG_CH_RESEL];
	wire allow_join = coord_assoc_flags[`PAS_FLAG_ALLOW_JOIN];
	wire pan_rs_e = enddev_assoc_flags[`PAS_FLAG_PAN_RESEL];
	wire ch_rs_e = enddev_assoc_flags[`PAS_FLAG_CH_RESEL];
	wire auto_join = enddev_assoc_flags[`PAS_FLAG_AUTO_JOIN];
	wire last_ch = (ch_q == CHW'(NCH - 1));
	wire nets_full = (nets_q == 3'(`PAS_MAX_NETS)); // [R4] [R15]
	wire coord_chg = cfg_write && (
		coord_assoc_flags[1:0] != cflags_last_q[1:0] ||
		pan_identifier != pan_last_q ||
		channel_select != ch_last_q ||
		short_source_addr != addr_last_q); // [R12]
	wire ed_chg = cfg_write && (enddev_assoc_flags != flags_last_q ||
		pan_identifier != pan_last_q ||
		channel_select != ch_last_q); // [R22]
	wire restart = !coord_enable && ed_chg && st_q != pas_pkg::PAS_IDLE;
	wire bcn_ok = bcn_permit && bcn_nonbeacon && // [R18]
		(pan_rs_e || bcn_pan == pan_identifier) && // [R16]
		(ch_rs_e || bcn_channel == channel_select); // [R17]
	////////////////////////////////////////////////////////////////
	// Unique pan search: first value upward not seen in scan
	logic [15:0] scan_pan;
	always_comb begin
		scan_pan = pan_identifier;
		for (int r = 0; r < `PAS_MAX_NETS; r++) begin
			for (int k = 0; k < `PAS_MAX_NETS; k++) begin
				if (nets_q > 3'(k) && npan_q[k] == scan_pan) begin
					scan_pan = scan_pan + 16'h0001; // [R5]
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Best channel and best coordinator
	logic [NCH*8-1:0] e_flat;
	logic [NCH*LQW-1:0] q_flat;
	logic e_found, q_found;
	logic [CHW-1:0] e_idx, q_idx;
	for (genvar i = 0; i < NCH; i++) begin : g_flat
		assign e_flat[i*8 +: 8] = emax_q[i];
		assign q_flat[i*LQW +: LQW] = ~clq_q[i]; // [R19]
	end
	pas_best_pick #(.N(NCH), .W(8)) u_epick (
		.vals(e_flat),
		.excl(did_active_q ? occ_q : {NCH{1'b0}}), // [R8]
		.found(e_found),
		.idx(e_idx)
	);
	pas_best_pick #(.N(NCH), .W(LQW)) u_qpick (
		.vals(q_flat),
		.excl(~cand_q),
		.found(q_found),
		.idx(q_idx)
	);
	////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		st_d = st_q;
		case (st_q)
		pas_pkg::PAS_IDLE: begin
			if (coord_enable) begin // [R1]
				st_d = pan_rs_c ? pas_pkg::PAS_SCAN_TX : // [R3] [R6]
					ch_rs_c ? pas_pkg::PAS_ESCAN : // [R9]
					pas_pkg::PAS_RUN;
			end else begin
				st_d = auto_join ? pas_pkg::PAS_SCAN_TX : // [R14]
					pas_pkg::PAS_RUN;
			end
		end
		pas_pkg::PAS_SCAN_TX: st_d = pas_pkg::PAS_SCAN_LISTEN;
		pas_pkg::PAS_SCAN_LISTEN: begin
			if (mac_scan_tick) begin
				if (last_ch || nets_full) begin // [R4] [R15]
					st_d = (coord_enable && ch_rs_c) ?
						pas_pkg::PAS_ESCAN : pas_pkg::PAS_PICK;
				end else begin
					st_d = pas_pkg::PAS_SCAN_TX; // [R24]
				end
			end
		end
		pas_pkg::PAS_ESCAN: begin
			if (mac_scan_tick && last_ch) begin // [R7]
				st_d = pas_pkg::PAS_PICK;
			end
		end
		pas_pkg::PAS_PICK: begin
			if (coord_enable) begin
				st_d = pas_pkg::PAS_RUN; // [R10]
			end else if (q_found) begin
				st_d = pas_pkg::PAS_ASSOC_TX;
			end else begin
				st_d = pas_pkg::PAS_FAIL; // [R20]
			end
		end
		pas_pkg::PAS_ASSOC_TX: st_d = pas_pkg::PAS_ASSOC_WAIT; // [R21]
		pas_pkg::PAS_ASSOC_WAIT: begin
			if (assoc_confirm) begin
				st_d = pas_pkg::PAS_RUN;
			end
		end
		pas_pkg::PAS_FAIL: begin
			st_d = (sleep_select != 3'h0) ? pas_pkg::PAS_FAIL :
				pas_pkg::PAS_IDLE; // [R20]
		end
		pas_pkg::PAS_RUN: st_d = pas_pkg::PAS_RUN;
		default: st_d = pas_pkg::PAS_IDLE;
		endcase
		if (restart) begin
			st_d = pas_pkg::PAS_IDLE; // [R22]
		end
	end
	wire scan_step = mac_scan_tick && (st_q == pas_pkg::PAS_SCAN_LISTEN ||
		st_q == pas_pkg::PAS_ESCAN);
	wire scan_end = scan_step && (last_ch ||
		(nets_full && st_q == pas_pkg::PAS_SCAN_LISTEN));
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_q <= pas_pkg::PAS_IDLE;
		end else begin
			st_q <= st_d;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst || st_q == pas_pkg::PAS_IDLE || scan_end) begin
			ch_q <= '0;
		end else if (scan_step) begin
			ch_q <= ch_q + CHW'(1); // [R24]
		end
	end
	////////////////////////////////////////////////////////////////
	// Scan result capture
	always_ff @(posedge sys_clk) begin
		if (!nrst || st_q == pas_pkg::PAS_IDLE) begin
			nets_q <= 3'h0;
			occ_q <= '0;
			cand_q <= '0;
			did_active_q <= 1'b0;
		end else if (st_q == pas_pkg::PAS_SCAN_LISTEN) begin
			did_active_q <= 1'b1;
			if (bcn_valid && !nets_full) begin
				npan_q[nets_q] <= bcn_pan; // [R4]
				nets_q <= nets_q + 3'h1;
				occ_q[bcn_channel] <= 1'b1;
				if (bcn_ok && (!cand_q[bcn_channel] ||
					bcn_lq > clq_q[bcn_channel])) begin
					cand_q[bcn_channel] <= 1'b1;
					clq_q[bcn_channel] <= bcn_lq;
					cpan_q[bcn_channel] <= bcn_pan;
				end
			end
		end
	end
	for (genvar i = 0; i < NCH; i++) begin : g_emax
		always_ff @(posedge sys_clk) begin
			if (!nrst || st_q == pas_pkg::PAS_IDLE) begin
				emax_q[i] <= 8'h00;
			end else if (st_q == pas_pkg::PAS_ESCAN && ed_valid &&
				ch_q == CHW'(i) && ed_level > emax_q[i]) begin
				emax_q[i] <= ed_level; // [R7]
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Operating settings and status
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pan_q <= 16'h0000;
			chan_q <= '0;
			started_q <= 1'b0;
			assoc_q <= 1'b0;
			ai_q <= `PAS_AI_NOT_STARTED;
			mac_rst_q <= 1'b0;
		end else begin
			mac_rst_q <= coord_enable && started_q && coord_chg; // [R12]
			if (st_q == pas_pkg::PAS_IDLE) begin
				pan_q <= pan_identifier; // [R6]
				chan_q <= channel_select; // [R9]
				started_q <= 1'b0;
				assoc_q <= 1'b0;
				ai_q <= coord_enable ? `PAS_AI_NOT_STARTED :
					`PAS_AI_SCANNING;
			end
			if (st_q == pas_pkg::PAS_PICK) begin
				if (coord_enable) begin
					if (did_active_q) pan_q <= scan_pan; // [R5]
					if (ch_rs_c && e_found) chan_q <= e_idx; // [R8]
				end else if (q_found) begin
					pan_q <= cpan_q[q_idx];
					chan_q <= q_idx;
					ai_q <= `PAS_AI_WAIT_CONF;
				end else begin
					ai_q <= `PAS_AI_NO_COORD; // [R23]
				end
			end
			if (st_q == pas_pkg::PAS_RUN) begin
				started_q <= coord_enable; // [R10]
				assoc_q <= !coord_enable; // [R14] [R21]
				ai_q <= `PAS_AI_OK;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cflags_last_q <= 8'h00;
			flags_last_q <= 8'h00;
			pan_last_q <= 16'h0000;
			ch_last_q <= '0;
			addr_last_q <= 16'h0000;
			hold_q <= 16'h0000;
		end else begin
			cflags_last_q <= coord_assoc_flags;
			flags_last_q <= enddev_assoc_flags;
			pan_last_q <= pan_identifier;
			ch_last_q <= channel_select;
			addr_last_q <= short_source_addr;
			if (!pend_valid || retention_period == 16'h0000) begin
				hold_q <= 16'h0000;
			end else if (hold_q != retention_period) begin
				hold_q <= hold_q + 16'h0001; // [R2]
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Outputs
	assign beacon_req = (st_q == pas_pkg::PAS_SCAN_TX); // [R3] [R15]
	assign req_dst_addr = `PAS_BCAST_ADDR;
	assign req_dst_pan = `PAS_BCAST_PAN;
	assign energy_scan = (st_q == pas_pkg::PAS_ESCAN);
	assign scan_channel = ch_q;
	assign scan_time = scan_duration;
	assign assoc_req = (st_q == pas_pkg::PAS_ASSOC_TX); // [R21]
	assign assoc_pan = pan_q;
	assign mac_reset = mac_rst_q;
	assign coord_started = started_q;
	assign join_accept_en = started_q && allow_join; // [R10]
	assign associated = assoc_q;
	assign active_pan = pan_q;
	assign active_channel = chan_q;
	assign send_direct = coord_enable && retention_period == 16'h0000;
	assign pend_hold = hold_q;
	assign pend_discard = pend_valid && retention_period != 16'h0000 &&
		hold_q == retention_period; // [R2]
	assign sleep_req = (st_q == pas_pkg::PAS_FAIL) &&
		sleep_select != 3'h0; // [R20]
	assign sleep_mode = sleep_select;
	assign assoc_indication = ai_q; // [R23]
	wire pas_pkg::pas_led_type led_mode =
		started_q ? pas_pkg::PAS_LED_1HZ : // [R11]
		!assoc_q ? pas_pkg::PAS_LED_ON :
		auto_join ? pas_pkg::PAS_LED_2HZ : pas_pkg::PAS_LED_5HZ; // [R14]
	pas_blinker u_led (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.mode(led_mode),
		.led(assoc_led)
	);
	////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_no_scan_clear: assert property (st_q == pas_pkg::PAS_IDLE && // [R6]
		coord_enable && !pan_rs_c |=> !beacon_req)
		else $error("active scan without pan_reselect");
	a_scan_limit: assert property (scan_step && nets_full |=> !beacon_req) // [R4]
		else $error("scan went on after five networks");
	a_join_gate: assert property (join_accept_en |-> allow_join) // [R10]
		else $error("joins accepted without allow_join");
	a_mac_reset: assert property (coord_chg && started_q && // [R12]
		coord_enable |=> mac_reset)
		else $error("mac not reset on setting change");
	a_assoc_wait: assert property (assoc_req |=> !associated // [R21]
		throughout (st_q == pas_pkg::PAS_ASSOC_WAIT))
		else $error("associated before confirm");
	a_fail_ai: assert property (st_q == pas_pkg::PAS_PICK && // [R23]
		!coord_enable && !q_found |=> assoc_indication == `PAS_AI_NO_COORD)
		else $error("failure not reported");
	a_ch_ascend: assert property (scan_step && !scan_end // [R24]
		|=> ch_q == $past(ch_q) + CHW'(1))
		else $error("scan channel not ascending");
	a_direct: assert property (retention_period == 16'h0000 // [R2]
		|-> !pend_discard)
		else $error("discard with zero retention");
	a_restart: assert property (restart |=> st_q == pas_pkg::PAS_IDLE) // [R22]
		else $error("no restart on setting change");
	a_noauto: assert property (st_q == pas_pkg::PAS_IDLE && // [R14]
		!coord_enable && !auto_join |=> ##1 associated)
		else $error("not associated without auto_join");
	c_coord_run: cover property (coord_started);
	c_assoc: cover property (assoc_req ##[1:100] associated);
	c_fail: cover property (sleep_req);
	c_escan: cover property (energy_scan ##1 st_q == pas_pkg::PAS_PICK);
endmodule : pas_seq

/* File: tb/pas_mac_model.sv */
/*
 Far side of the sequencer: MAC and peer coordinators.
 Assumes the bench loads the peer table; acts on the falling edge.
*/
`timescale 1ns/1ps
module pas_mac_model (
	input wire logic sys_clk,
	input wire logic beacon_req,
	input wire logic energy_scan,
	input wire logic [3:0] scan_channel,
	input wire logic assoc_req,
	output logic mac_scan_tick,
	output logic bcn_valid,
	output logic [15:0] bcn_pan,
	output logic [3:0] bcn_channel,
	output logic bcn_permit,
	output logic bcn_nonbeacon,
	output logic [7:0] bcn_lq,
	output logic ed_valid,
	output logic [7:0] ed_level,
	output logic assoc_confirm
);
	// Peer table and answer timing, set by the bench
	logic [15:0] net_on, net_permit, net_nb;
	logic [15:0] net_pan [16];
	logic [7:0] net_lq [16];
	logic [7:0] ed_tab [16];
	logic conf_en;
	int delay;
	logic [3:0] ch;
	////////////////////////////////////////////////////////////////
	// Set strobes, scramble data lines not in use
	task automatic step(input logic [3:0] s);
		@(negedge sys_clk);
		{mac_scan_tick, bcn_valid, ed_valid, assoc_confirm} <= s;
		if (!s[2]) begin
			bcn_pan <= ~bcn_pan;
			bcn_lq <= ~bcn_lq;
			bcn_channel <= ~bcn_channel;
		end
		if (!s[1]) ed_level <= ~ed_level;
	endtask : step
	////////////////////////////////////////////////////////////////
	initial begin
		{mac_scan_tick, bcn_valid, ed_valid, assoc_confirm} = 4'h0;
		{bcn_pan, bcn_channel, bcn_permit, bcn_nonbeacon} = 22'h0;
		{bcn_lq, ed_level} = 16'h0000;
		forever begin
			step(4'h0);
			ch = scan_channel;
			if (assoc_req === 1'b1) begin
				repeat (delay) step(4'h0);
				step({3'h0, conf_en});
			end else if (beacon_req === 1'b1 || energy_scan === 1'b1) begin
				repeat (delay) step(4'h0);
				if (energy_scan === 1'b1) begin
					step(4'h2);
					ed_level <= ed_tab[ch];
					step(4'h2);
					ed_level <= 8'h00;
				end else if (net_on[ch]) begin
					step(4'h4);
					bcn_pan <= net_pan[ch];
					bcn_channel <= ch;
					bcn_permit <= net_permit[ch];
					bcn_nonbeacon <= net_nb[ch];
					bcn_lq <= net_lq[ch];
				end else begin
					step(4'h0);
				end
				step(4'h8);
			end
		end
	end
endmodule : pas_mac_model

/* File: tb/tb.sv */
/*
 Self-checking bench for the association sequencer in both roles.
 Assumes pas_seq at sixteen channels beside the far-side model.
*/
`timescale 1ns/1ps
module tb;
	logic sys_clk, nrst, coord_enable, cfg_write, pend_valid;
	logic [7:0] coord_assoc_flags, enddev_assoc_flags;
	logic [15:0] pan_identifier, short_source_addr, retention_period;
	logic [15:0] scan_duration, bcn_pan, req_dst_addr, req_dst_pan;
	logic [15:0] scan_time, assoc_pan, active_pan, pend_hold, m;
	logic [3:0] channel_select, bcn_channel, scan_channel;
	logic [3:0] active_channel, last_ch;
	logic [2:0] sleep_select, sleep_mode;
	logic mac_scan_tick, bcn_valid, bcn_permit, bcn_nonbeacon, ed_valid;
	logic assoc_confirm, beacon_req, energy_scan, assoc_req, mac_reset;
	logic coord_started, join_accept_en, associated, send_direct;
	logic pend_discard, sleep_req, assoc_led;
	logic [7:0] bcn_lq, ed_level, assoc_indication;
	int errors, tests_run, n_bcn, n_mr, k, p;
	int seed = 32'h2EB93CF1;
	////////////////////////////////////////////////////////////////
	pas_seq uut (.sys_clk, .nrst, .coord_enable, .coord_assoc_flags,
		.enddev_assoc_flags, .pan_identifier, .channel_select,
		.short_source_addr, .retention_period, .scan_duration, .sleep_select,
		.cfg_write, .pend_valid, .mac_scan_tick, .bcn_valid, .bcn_pan,
		.bcn_channel, .bcn_permit, .bcn_nonbeacon, .bcn_lq, .ed_valid,
		.ed_level, .assoc_confirm, .beacon_req, .req_dst_addr, .req_dst_pan,
		.energy_scan, .scan_channel, .scan_time, .assoc_req, .assoc_pan,
		.mac_reset, .coord_started, .join_accept_en, .associated, .active_pan,
		.active_channel, .send_direct, .pend_hold, .pend_discard, .sleep_req,
		.sleep_mode, .assoc_indication, .assoc_led);
	pas_mac_model mac (.sys_clk, .beacon_req, .energy_scan, .scan_channel,
		.assoc_req, .mac_scan_tick, .bcn_valid, .bcn_pan, .bcn_channel,
		.bcn_permit, .bcn_nonbeacon, .bcn_lq, .ed_valid, .ed_level,
		.assoc_confirm);
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#400000;
		errors++;
		$display("unexpected at %0t: run hung", $time);
		wrap_up();
	end
	////////////////////////////////////////////////////////////////
	task automatic check_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: bit %b not %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: value %h not %h", $time, got, exp);
		end
	endtask : check_val
	task automatic wrap_up();
		$display("checks %0d, errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////
	// Beacon request order and addressing
	always @(negedge sys_clk) begin
		if (nrst !== 1'b1) begin
			n_bcn = 0;
			n_mr = 0;
		end else begin
			if (mac_reset === 1'b1) n_mr++;
			if (beacon_req === 1'b1) begin
				check_bit(scan_channel == 4'h0 || scan_channel == last_ch + 4'h1, 1'b1);
				check_val(req_dst_addr, 16'hFFFF);
				check_val(req_dst_pan, 16'hFFFF);
				last_ch = scan_channel;
				n_bcn++;
			end
		end
	end
	task automatic do_reset();
		nrst = 1'b0;
		repeat (4) @(negedge sys_clk);
		nrst = 1'b1;
	endtask : do_reset
	task automatic pulse_cfg();
		cfg_write = 1'b1;
		@(negedge sys_clk);
		cfg_write = 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask : pulse_cfg
	task automatic wait_on(input int sel);
		int n;
		n = 0;
		while (n < 3000 && !(sel == 0 ? coord_started === 1'b1 : sel == 1 ?
				associated === 1'b1 : assoc_indication === 8'h02)) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 3000) begin
			errors++;
			$display("unexpected at %0t: wait %0d expired", $time, sel);
		end
	endtask : wait_on
	task automatic rand_tab(input logic sure);
		pan_identifier = {1'b0, 15'($random(seed))};
		for (int c = 0; c < 16; c++) begin
			mac.net_on[c] = ($random(seed) & 3) == 0;
			mac.net_pan[c] = pan_identifier + 16'($random(seed) & 3);
			mac.net_permit[c] = ($random(seed) & 7) != 0;
			mac.net_nb[c] = ($random(seed) & 7) != 0;
			mac.net_lq[c] = {4'($random(seed)), 4'(c)};
			mac.ed_tab[c] = {4'($random(seed)), 4'(c)};
		end
		mac.delay = $random(seed) & 1;
		if (sure) begin
			mac.net_on[channel_select] = 1'b1;
			mac.net_pan[channel_select] = pan_identifier;
			mac.net_permit[channel_select] = 1'b1;
			mac.net_nb[channel_select] = 1'b1;
		end
	endtask : rand_tab
	// Networks the scan sees, and how many channels it visits
	task automatic found_mask();
		int n;
		n = 0;
		m = 16'h0000;
		p = 16;
		for (int c = 0; c < 16; c++)
			if (mac.net_on[c] && n < 5) begin
				m[c] = 1'b1;
				n++;
				if (n == 5) p = c + 1;
			end
	endtask : found_mask
	function automatic logic [15:0] exp_pan();
		logic [15:0] v;
		v = pan_identifier;
		for (int c = 0; c < 16; c++)
			if (m[c] && mac.net_pan[c] == v) begin
				v++;
				c = -1;
			end
		return v;
	endfunction : exp_pan
	function automatic logic [15:0] exp_ch(input logic act);
		int b;
		b = -1;
		for (int c = 0; c < 16; c++)
			if (!(act && m[c]) && (b < 0 || mac.ed_tab[c] < mac.ed_tab[b])) b = c;
		return 16'(b);
	endfunction : exp_ch
	function automatic int ed_pick(input logic [1:0] f);
		int b;
		b = -1;
		for (int c = 0; c < 16; c++)
			if (m[c] && mac.net_permit[c] && mac.net_nb[c]
					&& (f[0] || mac.net_pan[c] == pan_identifier)
					&& (f[1] || c == channel_select)
					&& (b < 0 || mac.net_lq[c] > mac.net_lq[b])) b = c;
		return b;
	endfunction : ed_pick
	////////////////////////////////////////////////////////////////
	initial begin
		{nrst, coord_enable, cfg_write, pend_valid} = 4'h0;
		{coord_assoc_flags, enddev_assoc_flags} = 16'h0000;
		{short_source_addr, retention_period} = 32'h0000_0000;
		{channel_select, sleep_select} = 7'h00;
		scan_duration = 16'h0040;
		errors = 0;
		tests_run = 0;
		mac.conf_en = 1'b1;
		rand_tab(1'b0);
		// Coordinator under every reselect setting
		for (int f = 0; f < 4; f++) begin
			coord_enable = 1'b1;
			coord_assoc_flags = 8'(f) | 8'($random(seed) & 4);
			retention_period = (f == 2) ? 16'h0008 : 16'h0000;
			pend_valid = 1'b0;
			rand_tab(1'b0);
			do_reset();
			@(negedge sys_clk);
			check_bit(assoc_led, 1'b1);
			wait_on(0);
			found_mask();
			check_val(active_pan, f[0] ? exp_pan() : pan_identifier);
			check_val(16'(active_channel), f[1] ? exp_ch(f[0]) : 16'(channel_select));
			check_val(16'(n_bcn), f[0] ? 16'(p) : 16'h0000);
			check_val(scan_time, scan_duration);
			check_bit(join_accept_en, coord_assoc_flags[2]);
			check_bit(send_direct, f != 2);
			pend_valid = 1'b1;
			repeat (6) @(negedge sys_clk);
			check_bit(pend_discard, 1'b0);
			repeat (6) @(negedge sys_clk);
			check_bit(pend_discard, f == 2);
			check_val(pend_hold, f == 2 ? 16'h0008 : 16'h0000);
		end
		coord_assoc_flags[2] = ~coord_assoc_flags[2];
		pulse_cfg();
		check_bit(join_accept_en, coord_assoc_flags[2]);
		check_val(16'(n_mr), 16'h0000);
		short_source_addr = short_source_addr + 16'h0001;
		pulse_cfg();
		check_val(16'(n_mr), 16'h0001);
		// End device: random peers under every filter setting
		for (int i = 0; i < 8; i++) begin
			coord_enable = 1'b0;
			enddev_assoc_flags = 8'h04 | 8'(i & 3);
			channel_select = 4'($random(seed) & 3);
			sleep_select = 3'($random(seed));
			rand_tab(i[0]);
			mac.conf_en = i != 7;
			do_reset();
			found_mask();
			k = ed_pick(i[1:0]);
			if (i == 7) begin
				repeat (400) @(negedge sys_clk);
				check_bit(associated, 1'b0);
				check_bit(assoc_led, 1'b1);
			end else if (k >= 0) begin
				wait_on(1);
				check_val(assoc_pan, mac.net_pan[k]);
				check_val(16'(active_channel), 16'(k));
				check_val({8'h00, assoc_indication}, 16'h0000);
				check_bit(coord_started, 1'b0);
			end else begin
				wait_on(2);
				check_bit(sleep_req, sleep_select != 3'h0);
				check_val(16'(sleep_mode), 16'(sleep_select));
				p = n_bcn;
				repeat (60) @(negedge sys_clk);
				check_bit(sleep_select == 3'h0 ? n_bcn > p : n_bcn == p, 1'b1);
			end
		end
		enddev_assoc_flags = 8'h03;
		mac.conf_en = 1'b1;
		do_reset();
		repeat (3) @(negedge sys_clk);
		check_bit(associated, 1'b1);
		check_val(16'(n_bcn), 16'h0000);
		enddev_assoc_flags = 8'h07;
		pulse_cfg();
		check_bit(associated, 1'b0);
		wait_on(1);
		check_bit(n_bcn > 0, 1'b1);
		wrap_up();
	end
endmodule : tb
